/* usp_top.sv */
`timescale 1ns/10ps
`default_nettype none
module usp_top
    import usp_pkg::*;
#(
    parameter int FDEPTH = usp_pkg::FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire usp_pkg::usp_cfg_s cfg,
    input  wire logic [8:0]       tx_data,
    input  wire logic             tx_write,
    input  wire logic             rx_read,
    input  wire logic             err_clear,
    input  wire logic             rx_line,
    output logic                  tx_line,
    output logic                  tx_ready,
    output logic [8:0]            rx_data,
    output logic                  rx_valid,
    output usp_pkg::usp_err_s     err,
    output logic                  rx_irq,
    output logic                  tx_irq,
    output logic                  dma_tx_req,
    output logic                  dma_rx_req,
    output logic                  dma_low_prio
);
    import usp_pkg::*;

    // Baud tick at sixteen times bit rate
    logic [15:0] bdiv;
    logic [15:0] next_bdiv;
    logic        tick;
    assign tick = (bdiv == 16'h0000);
    always_comb begin
        next_bdiv = tick ? ((cfg.divisor == 16'h0000) ? 16'h0000
                                                     : cfg.divisor - 16'h0001)
                         : bdiv - 16'h0001;
    end

    logic [3:0] nbits;
    assign nbits = 4'h5 + {2'h0, cfg.wlen};

    logic [8:0] f_tdata;
    logic       f_tvalid;
    logic       f_tready;
    logic       tx_pop;
    usp_fifo #(.WIDTH(9), .DEPTH(FDEPTH)) u_txq (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .in_data  (tx_data),
        .in_valid (tx_write),
        .in_ready (f_tready),
        .out_data (f_tdata),
        .out_valid(f_tvalid),
        .out_ready(tx_pop)
    );

    // Transmitter
    usp_state_e tst;
    usp_state_e next_tst;
    logic [8:0] tsh;
    logic [8:0] next_tsh;
    logic [3:0] tcnt;
    logic [3:0] next_tcnt;
    logic [3:0] tsub;
    logic [3:0] next_tsub;
    logic       tpar;
    logic       next_tpar;
    logic       next_tx_line;
    logic       tend;
    assign tend = tick && (tsub == 4'(OVS-1));

    always_comb begin
        next_tst     = tst;
        next_tsh     = tsh;
        next_tcnt    = tcnt;
        next_tpar    = tpar;
        next_tsub    = tick ? tsub + 4'h1 : tsub;
        next_tx_line = tx_line;
        tx_pop       = 1'b0;
        case (tst)
            USP_IDLE: begin
                next_tx_line = 1'b1;
                next_tsub    = 4'h0;
                if (f_tvalid) begin
                    tx_pop       = 1'b1;
                    next_tsh     = f_tdata;
                    if (cfg.nine_bit) begin
                        next_tsh[nbits] = f_tdata[8];
                    end
                    next_tpar    = 1'b0;
                    next_tx_line = 1'b0;
                    next_tst     = USP_START;
                end
            end
            USP_START: if (tend) begin
                next_tx_line = tsh[0];
                next_tpar    = tsh[0];
                next_tsh     = tsh >> 1;
                next_tcnt    = 4'h1;
                next_tst     = USP_DATA;
            end
            USP_DATA: if (tend) begin
                // ninth bit after data in nine-bit mode
                if (tcnt < nbits + {3'h0, cfg.nine_bit}) begin
                    next_tx_line = tsh[0];
                    next_tpar    = tpar ^ tsh[0];
                    next_tsh     = tsh >> 1;
                    next_tcnt    = tcnt + 4'h1;
                end else if (cfg.parity != USP_PAR_NONE) begin
                    next_tx_line = tpar ^ (cfg.parity == USP_PAR_ODD);
                    next_tst     = USP_PAR;
                end else begin
                    next_tx_line = 1'b1;
                    next_tcnt    = 4'h0;
                    next_tst     = USP_STOP;
                end
            end
            USP_PAR: if (tend) begin
                next_tx_line = 1'b1;
                next_tcnt    = 4'h0;
                next_tst     = USP_STOP;
            end
            USP_STOP: if (tend) begin
                if (cfg.two_stop && tcnt == 4'h0) begin
                    next_tcnt = 4'h1;
                end else begin
                    next_tst = USP_IDLE;
                end
            end
            default: next_tst = USP_IDLE;
        endcase
    end

    // Receiver input sync, three stages
    logic [2:0] rsync;
    logic       rin;
    logic       next_rin;
    assign next_rin = (rsync[2] == rsync[1]) ? rsync[1] : rin;

    usp_state_e rstate;
    usp_state_e next_rstate;
    logic [8:0] rsh;
    logic [8:0] next_rsh;
    logic [3:0] rcnt;
    logic [3:0] next_rcnt;
    logic [3:0] rsub;
    logic [3:0] next_rsub;
    logic       rpar;
    logic       next_rpar;
    logic       rdone;
    logic [8:0] rword;
    usp_err_s   rerr;
    logic       rmid;
    assign rmid = tick && (rsub == 4'(OVS/2-1));

    always_comb begin
        next_rstate = rstate;
        next_rsh    = rsh;
        next_rcnt   = rcnt;
        next_rpar   = rpar;
        next_rsub   = tick ? rsub + 4'h1 : rsub;
        rdone       = 1'b0;
        rword       = rsh >> (4'h9 - nbits - {3'h0, cfg.nine_bit});
        rerr        = '0;
        case (rstate)
            USP_IDLE: begin
                next_rsub = 4'h0;
                if (!rin) begin
                    next_rstate = USP_START;
                end
            end
            USP_START: if (rmid) begin
                next_rsub   = 4'(OVS/2);
                next_rstate = rin ? USP_IDLE : USP_DATA;
                next_rcnt   = 4'h0;
                next_rpar   = 1'b0;
            end
            USP_DATA: if (rmid) begin
                // LSB first into top of shifter
                next_rsh  = {rin, rsh[8:1]};
                next_rpar = rpar ^ rin;
                next_rcnt = rcnt + 4'h1;
                if (rcnt + 4'h1 == nbits + {3'h0, cfg.nine_bit}) begin
                    next_rstate = (cfg.parity != USP_PAR_NONE) ? USP_PAR
                                                               : USP_STOP;
                end
            end
            USP_PAR: if (rmid) begin
                next_rpar   = rpar ^ rin ^ (cfg.parity == USP_PAR_ODD);
                next_rstate = USP_STOP;
            end
            USP_STOP: if (rmid) begin
                rdone            = 1'b1;
                rerr.framing_err = !rin;
                rerr.parity_err  = (cfg.parity != USP_PAR_NONE) && rpar;
                rerr.addr_seen   = cfg.nine_bit && rword[nbits];
                next_rstate      = USP_IDLE;
            end
            default: next_rstate = USP_IDLE;
        endcase
    end

    logic [8:0] next_rx_data;
    logic       next_rx_valid;
    usp_err_s   next_err;
    always_comb begin
        next_rx_data  = rx_data;
        next_rx_valid = rx_valid && !rx_read;
        next_err      = err_clear ? usp_err_s'('0) : err;
        if (rdone) begin
            next_rx_data  = rword;
            next_rx_valid = 1'b1;
            next_err = next_err | rerr;
            next_err.overrun = next_err.overrun || (rx_valid && !rx_read);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bdiv         <= '0;
            tst          <= USP_IDLE;
            tsh          <= '0;
            tcnt         <= '0;
            tsub         <= '0;
            tpar         <= 1'b0;
            tx_line      <= 1'b1;
            rsync        <= 3'h7;
            rin          <= 1'b1;
            rstate       <= USP_IDLE;
            rsh          <= '0;
            rcnt         <= '0;
            rsub         <= '0;
            rpar         <= 1'b0;
            rx_data      <= '0;
            rx_valid     <= 1'b0;
            err          <= '0;
            tx_ready     <= 1'b0;
            rx_irq       <= 1'b0;
            tx_irq       <= 1'b0;
            dma_tx_req   <= 1'b0;
            dma_rx_req   <= 1'b0;
            dma_low_prio <= 1'b1;
        end else begin
            bdiv       <= next_bdiv;
            tst        <= next_tst;
            tsh        <= next_tsh;
            tcnt       <= next_tcnt;
            tsub       <= next_tsub;
            tpar       <= next_tpar;
            tx_line    <= next_tx_line;
            rsync      <= {rsync[1:0], rx_line};
            rin        <= next_rin;
            rstate     <= next_rstate;
            rsh        <= next_rsh;
            rcnt       <= next_rcnt;
            rsub       <= next_rsub;
            rpar       <= next_rpar;
            rx_data    <= next_rx_data;
            rx_valid   <= next_rx_valid;
            err        <= next_err;
            tx_ready   <= f_tready;
            rx_irq     <= next_rx_valid && !cfg.dma_mode;
            tx_irq     <= f_tready && !cfg.dma_mode;
            dma_tx_req <= f_tready && cfg.dma_mode;
            dma_rx_req <= next_rx_valid && cfg.dma_mode;
            dma_low_prio <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* usp_pkg.sv */
package usp_pkg;
    localparam int DATA_W_MAX    = 8;
    localparam int FIFO_DEPTH    = 32;
    localparam int OVS           = 16;
    localparam logic [15:0] DIV_RESET = 16'h0019;
    localparam logic [1:0] WLEN_RESET = 2'h3;
    localparam int ADDR_BIT      = 8;

    typedef enum logic [1:0] {
        USP_PAR_NONE,
        USP_PAR_EVEN,
        USP_PAR_ODD
    } usp_par_e;

    typedef struct packed {
        logic [15:0] divisor;
        logic [1:0]  wlen;
        logic        two_stop;
        usp_par_e    parity;
        logic        nine_bit;
        logic        dma_mode;
    } usp_cfg_s;

    typedef struct packed {
        logic parity_err;
        logic framing_err;
        logic overrun;
        logic addr_seen;
    } usp_err_s;

    typedef enum logic [2:0] {
        USP_IDLE,
        USP_START,
        USP_DATA,
        USP_PAR,
        USP_STOP
    } usp_state_e;
endpackage

/* usp_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module usp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr;
    logic [AW-1:0]    rptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wptr;
    logic [AW-1:0]    next_rptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_wptr  = push ? ((wptr == AW'(DEPTH-1)) ? '0 : wptr + 1'b1) : wptr;
        next_rptr  = pop ? ((rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1) : rptr;
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end else begin
            wptr  <= next_wptr;
            rptr  <= next_rptr;
            count <= next_count;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end
endmodule
`default_nettype wire

/* usp_top_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module usp_top_asserts
    import usp_pkg::*;
#(
    parameter int FDEPTH = usp_pkg::FIFO_DEPTH
) (
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire usp_pkg::usp_cfg_s cfg,
    input wire logic [8:0]        tx_data,
    input wire logic              tx_write,
    input wire logic              rx_read,
    input wire logic              err_clear,
    input wire logic              rx_line,
    input wire logic              tx_line,
    input wire logic              tx_ready,
    input wire logic [8:0]        rx_data,
    input wire logic              rx_valid,
    input wire usp_pkg::usp_err_s err,
    input wire logic              rx_irq,
    input wire logic              tx_irq,
    input wire logic              dma_tx_req,
    input wire logic              dma_rx_req,
    input wire logic              dma_low_prio
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_prio_fixed: assert property (dma_low_prio)
        else $error("dma_low_prio dropped");
    a_idle_after_rst: assert property ($fell(sys_rst) |-> tx_line)
        else $error("tx_line not idle high after reset");
    a_start_bit_len: assert property ($fell(tx_line) |-> !tx_line [*8])
        else $error("start bit too short");
    a_rx_irq_pio: assert property (
        $rose(rx_valid) && !cfg.dma_mode |-> ##[0:2] rx_irq)
        else $error("no receive interrupt");
    a_rx_dma_req: assert property (
        $rose(rx_valid) && cfg.dma_mode |->
            ##[0:2] (dma_rx_req && !rx_irq))
        else $error("no receive dma request");
    a_tx_irq_pio: assert property (
        (tx_ready && !cfg.dma_mode) [*3] |-> tx_irq && !dma_tx_req)
        else $error("no transmit interrupt");
    a_rx_hold: assert property (rx_valid && !rx_read |=> rx_valid)
        else $error("rx_valid dropped without read");
    a_rx_consume: assert property (rx_valid && rx_read |=> !rx_valid)
        else $error("rx_valid kept after read");
    a_err_sticky: assert property (
        !err_clear |=> (err & $past(err)) == $past(err))
        else $error("error flag lost without clear");
endmodule
bind usp_top usp_top_asserts #(.FDEPTH(FDEPTH)) usp_top_asserts_inst (.*);
`default_nettype wire

/* usp_remote.sv */
`timescale 1ns/10ps
`default_nettype none
module usp_remote (
    input  wire logic              clk,
    input  wire usp_pkg::usp_cfg_s cfg,
    input  wire logic              ser_in,
    output var logic               ser_out
);
    import usp_pkg::*;
    logic [8:0] got_q[$];
    logic       ok_q[$];
    logic [8:0] d;
    logic       ok;
    logic       pb;
    int         bt;
    initial ser_out = 1'b1;
    task automatic bit_out(input logic b);
        ser_out = b;
        repeat (16 * (int'(cfg.divisor) + 1)) @(posedge clk);
        #2;
    endtask
    task automatic send(input logic [8:0] v, input logic bad_par,
                        input logic bad_stop);
        logic p;
        p = bad_par;
        bit_out(1'b0);
        for (int i = 0; i < int'(cfg.wlen) + 5; i++) begin
            bit_out(v[i]);
            p ^= v[i];
        end
        if (cfg.nine_bit) begin
            bit_out(v[8]);
            p ^= v[8];
        end
        if (cfg.parity != USP_PAR_NONE)
            bit_out(p ^ (cfg.parity == USP_PAR_ODD));
        bit_out(!bad_stop);
        if (cfg.two_stop)
            bit_out(1'b1);
        ser_out = 1'b1;
    endtask
    always begin
        @(negedge ser_in);
        bt = 16 * (int'(cfg.divisor) + 1);
        repeat (bt / 2) @(posedge clk);
        ok = !ser_in;
        d = '0;
        pb = 1'b0;
        for (int i = 0; i < int'(cfg.wlen) + 5 + int'(cfg.nine_bit); i++) begin
            repeat (bt) @(posedge clk);
            d[i] = ser_in;
            pb ^= ser_in;
        end
        if (cfg.parity != USP_PAR_NONE) begin
            repeat (bt) @(posedge clk);
            ok &= (ser_in == (pb ^ (cfg.parity == USP_PAR_ODD)));
        end
        for (int i = 0; i < 1 + int'(cfg.two_stop); i++) begin
            repeat (bt) @(posedge clk);
            ok &= ser_in;
        end
        got_q.push_back(d);
        ok_q.push_back(ok);
    end
endmodule
`default_nettype wire

/* uart_serial_port_test.sv */
`timescale 1ns/10ps
`default_nettype none
module uart_serial_port_test;
    import usp_pkg::*;
    localparam int FD = 4;
    logic       clk, sys_rst, tx_write, rx_read, err_clear, rx_line, tx_line;
    logic       tx_ready, rx_valid, rx_irq, tx_irq, dma_tx_req, dma_rx_req;
    logic       dma_low_prio, rdy;
    logic [8:0] tx_data, rx_data, v, q[$];
    usp_cfg_s   cfg;
    usp_err_s   err;
    int         mismatches, num_checks;
    usp_top #(.FDEPTH(FD)) usp_top_inst (.clk(clk), .sys_rst(sys_rst),
        .cfg(cfg), .tx_data(tx_data), .tx_write(tx_write), .rx_read(rx_read),
        .err_clear(err_clear), .rx_line(rx_line), .tx_line(tx_line),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
        .err(err), .rx_irq(rx_irq), .tx_irq(tx_irq), .dma_tx_req(dma_tx_req),
        .dma_rx_req(dma_rx_req), .dma_low_prio(dma_low_prio));
    usp_remote usp_remote_inst (.clk(clk), .cfg(cfg), .ser_in(tx_line),
        .ser_out(rx_line));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string nm, input logic [8:0] got,
                         input logic [8:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    function automatic logic [8:0] exp9(input logic [8:0] d);
        int nb;
        nb = int'(cfg.wlen) + 5;
        return (d & ((9'h001 << nb) - 9'h001)) |
               (cfg.nine_bit ? (9'(d[8]) << nb) : 9'h000);
    endfunction
    task automatic wait_rx();
        for (int i = 0; i < 9000 && rx_valid !== 1'b1; i++) tick(1);
        if (rx_valid !== 1'b1) begin
            mismatches++;
            summarize();
        end
        tick(3);
    endtask
    task automatic rx_char(input logic [8:0] d);
        wait_rx();
        check("rx_data", rx_data, exp9(d));
        rx_read = 1'b1;
        tick(1);
        rx_read = 1'b0;
        tick(1);
    endtask
    task automatic wait_tx(input int k);
        for (int i = 0; i < 20000 && usp_remote_inst.got_q.size() < k; i++)
            tick(1);
        if (usp_remote_inst.got_q.size() < k) begin
            mismatches++;
            summarize();
        end
    endtask
    task automatic tx_char(input logic [8:0] d);
        for (int i = 0; i < 9000 && tx_ready !== 1'b1; i++) tick(1);
        if (tx_ready !== 1'b1) begin
            mismatches++;
            summarize();
        end
        tx_data = d;
        tx_write = 1'b1;
        tick(1);
        tx_write = 1'b0;
        wait_tx(1);
        check("tx_char", usp_remote_inst.got_q.pop_front(), exp9(d));
        check("tx_frame", 9'(usp_remote_inst.ok_q.pop_front()), 1);
    endtask
    task automatic clr();
        err_clear = 1'b1;
        tick(1);
        err_clear = 1'b0;
        tick(1);
    endtask
    initial begin
        cfg = '0;
        sys_rst = 1'b1;
        tx_data = '0;
        tx_write = 1'b0;
        rx_read = 1'b0;
        err_clear = 1'b0;
        mismatches = 0;
        num_checks = 0;
        tick(12);
        sys_rst = 1'b0;
        tick(4);
        check("tx_idle", 9'(tx_line), 1);
        check("low_prio", 9'(dma_low_prio), 1);
        check("tx_irq", 9'(tx_irq), 1);
        for (int w = 0; w < 4; w++) for (int p = 0; p < 3; p++)
            for (int s = 0; s < 2; s++) begin
                cfg.wlen = 2'(w);
                cfg.parity = usp_par_e'(p);
                cfg.two_stop = s[0];
                v = 9'h03c ^ 9'(w * 7 + p * 2 + s);
                tick(1);
                fork
                    tx_char(9'h0a5 + 9'(w * 12 + p * 4 + s));
                    usp_remote_inst.send(v, 1'b0, 1'b0);
                    rx_char(v);
                join
                check("err_none", 9'(err), 0);
            end
        cfg.parity = USP_PAR_ODD;
        fork
            usp_remote_inst.send(9'h011, 1'b1, 1'b0);
            rx_char(9'h011);
        join
        check("par_err", 9'(err.parity_err), 1);
        clr();
        check("err_clr", 9'(err), 0);
        usp_remote_inst.send(9'h022, 1'b0, 1'b1);
        tick(400);
        check("frame_err", 9'(err.framing_err), 1);
        rx_read = 1'b1;
        tick(1);
        rx_read = 1'b0;
        clr();
        usp_remote_inst.send(9'h033, 1'b0, 1'b0);
        tick(1);
        usp_remote_inst.send(9'h044, 1'b0, 1'b0);
        tick(60);
        check("overrun", 9'(err.overrun), 1);
        rx_char(9'h044);
        clr();
        cfg.nine_bit = 1'b1;
        cfg.parity = USP_PAR_EVEN;
        tick(1);
        fork
            tx_char(9'h1c3);
            usp_remote_inst.send(9'h15a, 1'b0, 1'b0);
            rx_char(9'h15a);
        join
        check("addr_seen", 9'(err.addr_seen), 1);
        clr();
        cfg.nine_bit = 1'b0;
        for (int k = 0; k < 20; k++) begin
            tx_data = 9'(k);
            tx_write = 1'b1;
            rdy = tx_ready;
            tick(1);
            tx_write = 1'b0;
            tick(1);
            if (rdy === 1'b1)
                q.push_back(9'(k));
        end
        check("fifo_full", 9'(tx_ready), 0);
        check("fifo_depth", 9'(q.size() >= FD), 1);
        wait_tx(q.size());
        foreach (q[i]) begin
            v = usp_remote_inst.got_q.pop_front();
            check("fifo_order", v, q[i]);
        end
        cfg.dma_mode = 1'b1;
        tick(40);
        check("dma_tx", 9'(dma_tx_req), 1);
        check("tx_irq_off", 9'(tx_irq), 0);
        fork
            usp_remote_inst.send(9'h0f0, 1'b0, 1'b0);
            wait_rx();
        join
        check("dma_rx", 9'(dma_rx_req), 1);
        check("rx_irq_off", 9'(rx_irq), 0);
        rx_char(9'h0f0);
        summarize();
    end
endmodule
`default_nettype wire
